// ### design/pmc_defines.svh
/*
 * Holds the numeric constants of the station management block:
 * frame codes, register addresses, field positions, reset values
 * and timing figures. Assumes it is included by bare name only.
 */
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ----------------------------------------------------------------
// management frame
// ----------------------------------------------------------------
`define PMC_PRE_ONES 6'd32
`define PMC_ST_CODE 2'b01
`define PMC_OP_RD 2'b10
`define PMC_OP_WR 2'b01
`define PMC_ADDR_BCAST 5'h00
`define PMC_ADDR_ALT 5'h03
`define PMC_HDR_BITS 5'd14
`define PMC_DATA_BITS 5'd16

// ----------------------------------------------------------------
// station register addresses and fields
// ----------------------------------------------------------------
`define PMC_REG_BASIC 5'h00
`define PMC_REG_CTRL1 5'h16
`define PMC_REG_IRQ 5'h1b
`define PMC_REG_CTRL2 5'h1f
`define PMC_B0_LOOP 14
`define PMC_B0_SPEED 13
`define PMC_B0_ANEG 12
`define PMC_B0_FDX 8
`define PMC_B16_NOBCAST 9
`define PMC_B1F_RLOOP 2
`define PMC_B1F_IRQLVL 9
`define PMC_B1F_AUTOX_OFF 13
`define PMC_B1F_FORCE_X 14
`define PMC_RST_BASIC 16'h3100
`define PMC_RST_CTRL1 16'h0000
`define PMC_RST_CTRL2 16'h0000

// ----------------------------------------------------------------
// axi4-lite map
// ----------------------------------------------------------------
`define PMC_AXI_IRQ_STAT 8'h00
`define PMC_AXI_IRQ_MASK 8'h04
`define PMC_AXI_CFG 8'h08
`define PMC_AXI_STATE 8'h0c
`define PMC_AXI_EVT_BUSY 0
`define PMC_AXI_EVT_WRITE 1
`define PMC_AXI_EVT_XSWAP 2
`define PMC_RESP_OK 2'b00
`define PMC_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PMC_CLK_NS 100
`define PMC_XOVER_MS 2
`define PMC_XOVER_CYC ((`PMC_XOVER_MS * 1000000) / `PMC_CLK_NS)

`endif

// ### design/pmc_mgmt.sv
/*
 * Station management slave with interrupt, crossover and loopback
 * control, plus an axi4-lite window for the host-side status.
 * Assumes mdc and mdio pins are asynchronous to clk and that
 * the link clock is slow enough for clk to see every edge.
 */
// Functional notes
// - answer only at strap-selected address
// - address zero broadcasts after reset
// - bit nine of 16h disables broadcast
// - preamble, start, op, addresses, turnaround, data
// - read turnaround: release, then device drives zero
// - five-bit field selects 32 registers
// - interrupt only for enabled conditions
// - status bits clear on read of 1Bh
// - interrupt polarity from 1Fh bit nine
// - auto crossover default on, 1Fh bit13 off
// - forced crossover from 1Fh bit fourteen
// - auto crossover follows partner pair use
// - local loopback needs loop, fixed speed, duplex
// - local loopback returns frames, still transmits
// - local loopback both speeds, full duplex only
// - remote loopback only at 100 full duplex
// - remote loopback enabled by 1Fh bit two
`timescale 1ns/1ns
`include "pmc_defines.svh"
module pmc_mgmt import pmc_pkg::*; #(
   parameter int unsigned XOVER_CYC = `PMC_XOVER_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] station_addr_strap,
   input wire logic mdcIn,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   input wire logic [7:0] irqEvents,
   input wire logic rxEnergy,
   input wire logic [15:0] linkStatus,
   output logic irq_out,
   output logic hostIrq,
   output pmc_mode_t mode,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   logic mdcS;
   logic mdioS;
   logic mdcD_ff;
   logic mdcRise;

   pmc_sync3 u_syncMdc (.clk(clk), .srst(srst), .din(mdcIn), .dout(mdcS));
   pmc_sync3 u_syncMdio (.clk(clk), .srst(srst), .din(mdioIn), .dout(mdioS));

   // edge finder on the filtered clock
   always_ff @(posedge clk) begin
      if (srst) mdcD_ff <= 1'b1;
      else mdcD_ff <= mdcS;
   end
   assign mdcRise = mdcS & ~mdcD_ff;

   // ----------------------------------------------------------------
   // station registers
   // ----------------------------------------------------------------
   logic [15:0] basic_ff;
   logic [15:0] ctrl1_ff;
   logic [15:0] ctrl2_ff;
   logic [7:0] irqEn_ff;
   logic [7:0] irqStat_ff;
   logic [4:0] myAddr_ff;
   logic mdixNow;
   logic xSwap;

   // strap caught by a clocked process at reset release
   always_ff @(posedge clk) begin
      if (srst) myAddr_ff <= station_addr_strap == 2'b00 ? `PMC_ADDR_BCAST : `PMC_ADDR_ALT;
   end

   // ----------------------------------------------------------------
   // frame receiver
   // ----------------------------------------------------------------
   pmc_state_t state_ff;
   logic [5:0] ones_ff;
   logic [4:0] cnt_ff;
   logic [13:0] hdrSh_ff;
   logic [15:0] sh_ff;
   logic wrDo;
   logic rdDo;
   logic selected;
   pmc_hdr_t hdr;

   assign hdr = pmc_hdr_t'(hdrSh_ff[11:0]);
   // unique address, or zero while still broadcast
   assign selected = (hdr.phy == myAddr_ff) ||
      (hdr.phy == `PMC_ADDR_BCAST && !ctrl1_ff[`PMC_B16_NOBCAST]);

   function automatic logic [15:0] regRead(input logic [4:0] a, input logic [15:0] b,
         input logic [15:0] c1, input logic [15:0] c2, input logic [7:0] en,
         input logic [7:0] st, input logic [15:0] ls);
      if (a == `PMC_REG_BASIC) regRead = b;
      else if (a == `PMC_REG_CTRL1) regRead = c1;
      else if (a == `PMC_REG_IRQ) regRead = {en, st};
      else if (a == `PMC_REG_CTRL2) regRead = c2;
      else regRead = ls;
   endfunction

   // serial state machine, one step per rising mdc
   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff <= PMC_IDLE;
         ones_ff <= '0;
         cnt_ff <= '0;
         hdrSh_ff <= '0;
         sh_ff <= '0;
         mdioOut <= 1'b1;
         mdioOe <= 1'b0;
      end else if (mdcRise) begin
         case (state_ff)
            PMC_IDLE, PMC_PRE: begin
               mdioOe <= 1'b0;
               if (mdioS) begin
                  if (ones_ff != `PMC_PRE_ONES) ones_ff <= ones_ff + 6'd1;
                  state_ff <= PMC_PRE;
               end else if (ones_ff == `PMC_PRE_ONES) begin
                  // start code's leading zero seen
                  state_ff <= PMC_HDR;
                  cnt_ff <= '0;
                  hdrSh_ff <= '0;
                  ones_ff <= '0;
               end else begin
                  ones_ff <= '0;
                  state_ff <= PMC_IDLE;
               end
            end
            PMC_HDR: begin
               hdrSh_ff <= {hdrSh_ff[12:0], mdioS};
               cnt_ff <= cnt_ff + 5'd1;
               if (cnt_ff == `PMC_HDR_BITS - 5'd2) begin
                  state_ff <= PMC_TA;
                  cnt_ff <= '0;
               end
            end
            PMC_TA: begin
               // header now complete: start bit, op, phy, reg
               if ({1'b0, hdrSh_ff[12]} != `PMC_ST_CODE ||
                     (hdr.op != `PMC_OP_RD && hdr.op != `PMC_OP_WR) || !selected) begin
                  state_ff <= PMC_IDLE;
               end else if (cnt_ff == 5'd0) begin
                  cnt_ff <= 5'd1;
                  if (hdr.op == `PMC_OP_RD) begin
                     mdioOe <= 1'b1;
                     mdioOut <= 1'b0;
                     sh_ff <= regRead(hdr.reg_a, basic_ff, ctrl1_ff, ctrl2_ff,
                        irqEn_ff, irqStat_ff, linkStatus);
                  end
               end else begin
                  state_ff <= PMC_DATA;
                  cnt_ff <= '0;
                  if (hdr.op == `PMC_OP_RD) begin
                     mdioOut <= sh_ff[15];
                     sh_ff <= {sh_ff[14:0], 1'b0};
                  end
               end
            end
            PMC_DATA: begin
               cnt_ff <= cnt_ff + 5'd1;
               if (hdr.op == `PMC_OP_RD) begin
                  mdioOut <= sh_ff[15];
                  sh_ff <= {sh_ff[14:0], 1'b0};
               end else begin
                  sh_ff <= {sh_ff[14:0], mdioS};
               end
               // release with the last bit so the idle bit floats
               if (cnt_ff == `PMC_DATA_BITS - 5'd1) begin
                  state_ff <= PMC_DONE;
                  mdioOe <= 1'b0;
               end
            end
            default: begin
               mdioOe <= 1'b0; // idle: line released
               mdioOut <= 1'b1;
               state_ff <= PMC_IDLE;
               ones_ff <= {5'd0, mdioS};
            end
         endcase
      end
   end

   assign wrDo = mdcRise && state_ff == PMC_DONE && hdr.op == `PMC_OP_WR;
   assign rdDo = mdcRise && state_ff == PMC_TA && cnt_ff == 5'd0 && selected &&
      hdr.op == `PMC_OP_RD && {1'b0, hdrSh_ff[12]} == `PMC_ST_CODE;

   // writable registers
   always_ff @(posedge clk) begin
      if (srst) begin
         basic_ff <= `PMC_RST_BASIC;
         ctrl1_ff <= `PMC_RST_CTRL1;
         ctrl2_ff <= `PMC_RST_CTRL2;
         irqEn_ff <= '0;
      end else if (wrDo) begin
         if (hdr.reg_a == `PMC_REG_BASIC) basic_ff <= sh_ff;
         else if (hdr.reg_a == `PMC_REG_CTRL1) ctrl1_ff <= sh_ff;
         else if (hdr.reg_a == `PMC_REG_IRQ) irqEn_ff <= sh_ff[15:8];
         else if (hdr.reg_a == `PMC_REG_CTRL2) ctrl2_ff <= sh_ff;
      end
   end

   // sticky status, set wins over clear-on-read
   always_ff @(posedge clk) begin
      if (srst) irqStat_ff <= '0;
      else if (rdDo && hdr.reg_a == `PMC_REG_IRQ) irqStat_ff <= irqEvents;
      else irqStat_ff <= irqStat_ff | irqEvents;
   end

   // pin level: asserted when any enabled status bit set
   always_ff @(posedge clk) begin
      if (srst) irq_out <= 1'b1;
      else irq_out <= (|(irqStat_ff & irqEn_ff)) == ctrl2_ff[`PMC_B1F_IRQLVL];
   end

   // ----------------------------------------------------------------
   // crossover and loopback
   // ----------------------------------------------------------------
   pmc_xover #(.XOVER_CYC(XOVER_CYC)) u_xover (
      .clk(clk),
      .srst(srst),
      .autoOff(ctrl2_ff[`PMC_B1F_AUTOX_OFF]),
      .forceX(ctrl2_ff[`PMC_B1F_FORCE_X]),
      .rxEnergy(rxEnergy),
      .mdix(mdixNow),
      .swapPulse(xSwap)
   );

   // loopback allowed only in its supported speed and duplex
   always_ff @(posedge clk) begin
      if (srst) mode <= '0;
      else begin
         mode.localLoop <= basic_ff[`PMC_B0_LOOP] && !basic_ff[`PMC_B0_ANEG] &&
            basic_ff[`PMC_B0_FDX];
         mode.remoteLoop <= ctrl2_ff[`PMC_B1F_RLOOP] && basic_ff[`PMC_B0_SPEED] &&
            basic_ff[`PMC_B0_FDX];
         mode.mdixSel <= mdixNow;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite host window
   // ----------------------------------------------------------------
   logic [2:0] hStat_ff;
   logic [2:0] hMask_ff;
   logic [2:0] hEvt;
   logic wTake;
   logic rTake;

   assign hEvt = {xSwap, wrDo, rdDo};
   assign wTake = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
   assign rTake = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;

   // write channel: both taken together, one answer
   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMC_RESP_OK;
         hMask_ff <= '0;
      end else begin
         s_axi_awready <= wTake;
         s_axi_wready <= wTake;
         if (wTake) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `PMC_RESP_OK;
            if (s_axi_awaddr == `PMC_AXI_IRQ_MASK) begin
               if (s_axi_wstrb[0]) hMask_ff <= s_axi_wdata[2:0];
            end else if (s_axi_awaddr != `PMC_AXI_IRQ_STAT) begin
               s_axi_bresp <= `PMC_RESP_SLVERR;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // host status: write one to clear, new events win
   always_ff @(posedge clk) begin
      if (srst) hStat_ff <= '0;
      else if (wTake && s_axi_awaddr == `PMC_AXI_IRQ_STAT && s_axi_wstrb[0])
         hStat_ff <= (hStat_ff & ~s_axi_wdata[2:0]) | hEvt;
      else hStat_ff <= hStat_ff | hEvt;
   end

   always_ff @(posedge clk) begin
      if (srst) hostIrq <= 1'b0;
      else hostIrq <= |(hStat_ff & hMask_ff);
   end

   // read channel
   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `PMC_RESP_OK;
      end else begin
         s_axi_arready <= rTake;
         if (rTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PMC_RESP_OK;
            if (s_axi_araddr == `PMC_AXI_IRQ_STAT) s_axi_rdata <= {29'd0, hStat_ff};
            else if (s_axi_araddr == `PMC_AXI_IRQ_MASK) s_axi_rdata <= {29'd0, hMask_ff};
            else if (s_axi_araddr == `PMC_AXI_CFG) s_axi_rdata <= {ctrl2_ff, ctrl1_ff};
            else if (s_axi_araddr == `PMC_AXI_STATE)
               s_axi_rdata <= {8'd0, irqStat_ff, 10'd0, mode, state_ff};
            else begin
               s_axi_rdata <= '0;
               s_axi_rresp <= `PMC_RESP_SLVERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_bcastOff;
      @(posedge clk) disable iff (srst)
         (ctrl1_ff[`PMC_B16_NOBCAST] && myAddr_ff != `PMC_ADDR_BCAST &&
         hdr.phy == `PMC_ADDR_BCAST) |-> !selected;
   endproperty
   a_bcastOff: assert property (p_bcastOff) else $error("zero still broadcast");
   property p_rdTa;
      @(posedge clk) disable iff (srst) rdDo |=> (mdioOe && !mdioOut);
   endproperty
   a_rdTa: assert property (p_rdTa) else $error("read turnaround not zero");
   property p_clrRead;
      @(posedge clk) disable iff (srst)
         (rdDo && hdr.reg_a == `PMC_REG_IRQ && irqEvents == 8'h00) |=> irqStat_ff == 8'h00;
   endproperty
   a_clrRead: assert property (p_clrRead) else $error("status not cleared");
   property p_irqEn;
      @(posedge clk) disable iff (srst)
         (irq_out == $past(ctrl2_ff[`PMC_B1F_IRQLVL])) |-> $past(irqStat_ff & irqEn_ff) != 8'h00;
   endproperty
   a_irqEn: assert property (p_irqEn) else $error("irq without enable");
   property p_rloop;
      @(posedge clk) disable iff (srst) mode.remoteLoop |-> $past(basic_ff[`PMC_B0_SPEED]);
   endproperty
   a_rloop: assert property (p_rloop) else $error("remote loop at wrong speed");
   property p_lloop;
      @(posedge clk) disable iff (srst) mode.localLoop |-> $past(basic_ff[`PMC_B0_FDX]);
   endproperty
   a_lloop: assert property (p_lloop) else $error("local loop half duplex");
   property p_drvEdge;
      @(posedge clk) disable iff (srst) $changed(mdioOut) |-> $past(mdcRise);
   endproperty
   a_drvEdge: assert property (p_drvEdge) else $error("drive off rising edge");
   property p_quiet;
      @(posedge clk) disable iff (srst) (state_ff == PMC_HDR) |-> !mdioOe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("drove during header");
endmodule

// ### design/pmc_pkg.sv
/*
 * Types shared by the station management block.
 * Assumes pmc_defines.svh is on the include path.
 */
package pmc_pkg;
   // frame receiver states, gray along the usual path
   typedef enum logic [2:0] {
      PMC_IDLE = 3'b000,
      PMC_PRE = 3'b001,
      PMC_HDR = 3'b011,
      PMC_TA = 3'b010,
      PMC_DATA = 3'b110,
      PMC_DONE = 3'b111
   } pmc_state_t;

   // decoded frame header
   typedef struct packed {
      logic [1:0] op;
      logic [4:0] phy;
      logic [4:0] reg_a;
   } pmc_hdr_t;

   // control outputs toward the data path
   typedef struct packed {
      logic localLoop;
      logic remoteLoop;
      logic mdixSel;
   } pmc_mode_t;
endpackage

// ### design/pmc_sync3.sv
/*
 * Three stage synchroniser with agreement filter.
 * Assumes the input comes from outside the clk domain.
 */
`timescale 1ns/1ns
module pmc_sync3 (
   input wire logic clk,
   input wire logic srst,
   input wire logic din,
   output logic dout
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (srst) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // change counts once stages two and three agree
   always_ff @(posedge clk) begin
      if (srst) begin
         dout <= 1'b1;
      end else if (s2_ff == s3_ff) begin
         dout <= s3_ff;
      end
   end
endmodule

// ### design/pmc_xover.sv
/*
 * Crossover pair selection: automatic search or forced choice.
 * Assumes energy detect comes in synchronous to clk.
 */
`timescale 1ns/1ns
`include "pmc_defines.svh"
module pmc_xover import pmc_pkg::*; #(
   parameter int unsigned XOVER_CYC = `PMC_XOVER_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic autoOff,
   input wire logic forceX,
   input wire logic rxEnergy,
   output logic mdix,
   output logic swapPulse
);
   // elaboration check: the dwell counter needs two states at least
   if (XOVER_CYC < 2) begin : g_dwellChk
      $error("xover dwell too short");
   end

   logic [31:0] dwell_ff;

   // hop pairs until the partner's transmit is heard
   always_ff @(posedge clk) begin
      if (srst) begin
         mdix <= 1'b0;
         dwell_ff <= '0;
         swapPulse <= 1'b0;
      end else begin
         swapPulse <= 1'b0;
         if (autoOff) begin
            if (mdix != forceX) swapPulse <= 1'b1;
            mdix <= forceX;
            dwell_ff <= '0;
         end else if (rxEnergy) begin
            dwell_ff <= '0;
         end else if (dwell_ff == XOVER_CYC - 1) begin
            mdix <= ~mdix;
            swapPulse <= 1'b1;
            dwell_ff <= '0;
         end else begin
            dwell_ff <= dwell_ff + 32'd1;
         end
      end
   end

   property p_force;
      @(posedge clk) disable iff (srst) autoOff |=> (mdix == $past(forceX));
   endproperty
   a_force: assert property (p_force) else $error("forced pair wrong");
endmodule

// ### tb/pmc_sta_model.sv
/*
 * Controller-side model of the station management link: makes the link
 * clock during frames only and drives or releases the data line.
 * Assumes a pull-up on the shared data line and a design that drives
 * its data after rising link clock edges.
 */
`timescale 1ns/1ns
module pmc_sta_model (
   output logic mdc,
   output wire mdio,
   input wire logic devOut,
   input wire logic devOe
);
   logic drvOe;
   logic drvOut;

   // ----------------------------------------------------------------
   // shared data line
   // ----------------------------------------------------------------
   // released by both ends the pull-up wins, never a stale value
   assign mdio = devOe ? devOut : (drvOe ? drvOut : 1'b1);

   // idle: clock stands still high, line released
   initial begin
      mdc = 1'b1;
      drvOe = 1'b0;
      drvOut = 1'b1;
   end

   // ----------------------------------------------------------------
   // frame tasks
   // ----------------------------------------------------------------
   // drive in the low phase, sample at the rising edge, 800 ns period
   task automatic bitIo(input logic oe, input logic v, output logic s);
      mdc = 1'b0;
      drvOe = oe;
      drvOut = v;
      #400;
      mdc = 1'b1;
      s = mdio;
      #400;
   endtask

   // rd holds the second turnaround bit and the data as seen on the line
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] wd, output logic [16:0] rd);
      logic [63:0] f;
      logic s;
      int i;
      f = {32'hffffffff, 2'b01, op, phy, ra, (op == 2'b10) ? 2'b11 : 2'b10, wd};
      rd = '0;
      #10; // step off the clk edge so pin edges never race the sampler
      for (i = 63; i >= 0; i--) begin
         bitIo((op != 2'b10) || (i > 17), f[i], s);
         if (i <= 16) rd[i] = s;
      end
      bitIo(1'b0, 1'b1, s);
      drvOe = 1'b0;
   endtask
endmodule

// ### tb/tb.sv
/*
 * Directed bench for the station management block: register bus and
 * link tasks, then tests as sequences of calls with expected values.
 * Assumes pmc_sta_model plays the controller on the link.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb import pmc_pkg::*; ;
   logic clk;
   logic srst;
   logic [1:0] strap;
   logic [7:0] irqEvents;
   logic rxEnergy;
   logic [15:0] linkStatus;
   wire mdc;
   wire mdio;
   logic mdioOut, mdioOe, irq_out, hostIrq;
   pmc_mode_t mode;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;

   // short crossover dwell keeps the run brief
   pmc_mgmt #(.XOVER_CYC(20)) pmc_mgmt_i (.clk, .srst, .station_addr_strap(strap),
      .mdcIn(mdc), .mdioIn(mdio), .mdioOut, .mdioOe, .irqEvents, .rxEnergy, .linkStatus,
      .irq_out, .hostIrq, .mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   pmc_sta_model pmc_sta_model_i (.mdc, .mdio, .devOut(mdioOut), .devOe(mdioOe));

   // ----------------------------------------------------------------
   // clock, timeout, verdict
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // about 26 frames of 520 cycles each, ceiling well above that
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   // address and data offered together, each released when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] er);
      bit fin;
      fin = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!fin) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            `CHK(s_axi_bresp, er)
            fin = 1'b1;
         end
      end
      @(posedge clk); // next call must not re-raise valid in this step
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      bit fin;
      fin = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!fin) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            `CHK(s_axi_rresp, er)
            if (er == 2'b00) `CHK(s_axi_rdata, ed)
            fin = 1'b1;
         end
      end
      @(posedge clk);
   endtask

   // link frames realign to clk afterwards; 1ffff means nobody answered
   task automatic mrd(input logic [4:0] phy, input logic [4:0] ra, input logic [16:0] ex);
      logic [16:0] r;
      pmc_sta_model_i.xfer(2'b10, phy, ra, 16'h0000, r);
      `CHK(r, ex)
      @(posedge clk);
   endtask

   task automatic mwr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
      logic [16:0] r;
      pmc_sta_model_i.xfer(2'b01, phy, ra, wd, r);
      repeat (8) @(posedge clk); // register and mode land after the idle rise
   endtask

   task automatic evt(input logic [7:0] e, input logic lvl);
      irqEvents <= e;
      @(posedge clk);
      irqEvents <= 8'h00;
      repeat (3) @(posedge clk);
      `CHK(irq_out, lvl)
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      logic b;
      int n;
      srst = 1'b1;
      strap = 2'b11;
      irqEvents = 8'h00;
      rxEnergy = 1'b1;
      linkStatus = 16'h5a3c;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      // reset values, addressing and the 32 entry space
      `CHK(irq_out, 1'b1)
      `CHK(mode, 3'b000)
      mrd(5'h03, 5'h00, 17'h03100);
      mrd(5'h03, 5'h01, {1'b0, linkStatus});
      mrd(5'h03, 5'h1f, 17'h00000);
      mrd(5'h01, 5'h00, 17'h1ffff);
      mrd(5'h00, 5'h16, 17'h00000);
      $display("test reset done");
      // loopback: local at both speeds full duplex, remote at 100 full only
      mwr(5'h00, 5'h00, 16'h4100);
      `CHK(mode.localLoop, 1'b1)
      mwr(5'h03, 5'h00, 16'h6100);
      `CHK(mode.localLoop, 1'b1)
      mwr(5'h03, 5'h00, 16'h4000);
      `CHK(mode.localLoop, 1'b0)
      mwr(5'h03, 5'h00, 16'h2100);
      mwr(5'h03, 5'h1f, 16'h0004);
      `CHK(mode.remoteLoop, 1'b1)
      mwr(5'h03, 5'h00, 16'h0100);
      `CHK(mode.remoteLoop, 1'b0)
      mwr(5'h03, 5'h1f, 16'h0000);
      $display("test loopback done");
      // crossover forced both ways, then automatic search and lock
      mwr(5'h03, 5'h1f, 16'h6000);
      `CHK(mode.mdixSel, 1'b1)
      mwr(5'h03, 5'h1f, 16'h2000);
      `CHK(mode.mdixSel, 1'b0)
      mwr(5'h03, 5'h1f, 16'h0000);
      b = mode.mdixSel;
      rxEnergy <= 1'b0;
      n = 0;
      while (mode.mdixSel === b && n < 80) begin
         @(posedge clk);
         n++;
      end
      `CHK(mode.mdixSel, ~b)
      rxEnergy <= 1'b1;
      repeat (5) @(posedge clk);
      b = mode.mdixSel;
      repeat (80) @(posedge clk);
      `CHK(mode.mdixSel, b)
      $display("test crossover done");
      // interrupt enables, clear on read, polarity
      mwr(5'h03, 5'h1b, 16'h0100);
      evt(8'h02, 1'b1);
      evt(8'h01, 1'b0);
      mrd(5'h03, 5'h1b, 17'h00103);
      `CHK(irq_out, 1'b1)
      mrd(5'h03, 5'h1b, 17'h00100);
      mwr(5'h03, 5'h1f, 16'h0200);
      `CHK(irq_out, 1'b0)
      evt(8'h01, 1'b1);
      mrd(5'h03, 5'h1b, 17'h00101);
      $display("test interrupt done");
      // broadcast off, wrong station ignored
      mwr(5'h00, 5'h16, 16'h0200);
      mwr(5'h01, 5'h16, 16'hffff);
      mrd(5'h03, 5'h16, 17'h00200);
      mrd(5'h00, 5'h16, 17'h1ffff);
      axr(8'h08, 32'h02000200, 2'b00);
      $display("test broadcast done");
      // host status, mask, write one to clear, unmapped place
      axw(8'h00, 32'h7, 2'b00);
      axw(8'h04, 32'h2, 2'b00);
      mrd(5'h03, 5'h16, 17'h00200);
      `CHK(hostIrq, 1'b0)
      mwr(5'h03, 5'h16, 16'h0200);
      `CHK(hostIrq, 1'b1)
      axr(8'h00, 32'h3, 2'b00);
      axw(8'h00, 32'h2, 2'b00);
      repeat (2) @(posedge clk);
      `CHK(hostIrq, 1'b0)
      axw(8'h10, 32'hffffffff, 2'b10);
      axr(8'h10, 32'h0, 2'b10);
      axr(8'h04, 32'h2, 2'b00);
      $display("test host done");
      conclude();
   end
endmodule
